// File: bmrf_pkg.sv
// Package with constants and types for the banked mode register file
package bmrf_pkg;
    localparam int unsigned XLEN         = 32;
    localparam int unsigned NUM_GP_PHYS  = 31;
    localparam int unsigned NUM_SAVED    = 5;
    localparam int unsigned PC_INDEX     = 15;
    localparam int unsigned SP_INDEX     = 13;
    localparam int unsigned RA_INDEX     = 14;
    localparam int unsigned BANK_LO      = 8;
    localparam int unsigned FAST_LO      = 8;
    localparam int unsigned FAST_HI      = 12;
    localparam int unsigned COND_HI      = 31;
    localparam int unsigned COND_LO      = 28;
    localparam int unsigned WIDE_INSN_W  = 32;
    localparam int unsigned COMPACT_W    = 16;

    // Status word field positions
    localparam int unsigned SW_NEG_BIT   = 31;
    localparam int unsigned SW_ZERO_BIT  = 30;
    localparam int unsigned SW_CARRY_BIT = 29;
    localparam int unsigned SW_OVF_BIT   = 28;
    localparam int unsigned SW_IRQD_BIT  = 7;
    localparam int unsigned SW_FIQD_BIT  = 6;
    localparam int unsigned SW_STATE_BIT = 5;
    localparam int unsigned SW_MODE_HI   = 4;
    localparam int unsigned SW_MODE_LO   = 0;

    // Mode field encodings
    localparam logic [4:0] MODE_USER   = 5'h10;
    localparam logic [4:0] MODE_FAST   = 5'h11;
    localparam logic [4:0] MODE_IRQ    = 5'h12;
    localparam logic [4:0] MODE_SUPV   = 5'h13;
    localparam logic [4:0] MODE_ABORT  = 5'h17;
    localparam logic [4:0] MODE_UNDEF  = 5'h1b;
    localparam logic [4:0] MODE_SYSTEM = 5'h1f;

    // Exception vector addresses
    localparam logic [31:0] VEC_UNDEF  = 32'h0000_0004;
    localparam logic [31:0] VEC_TRAP   = 32'h0000_0008;
    localparam logic [31:0] VEC_ABORT  = 32'h0000_0010;
    localparam logic [31:0] VEC_IRQ    = 32'h0000_0018;
    localparam logic [31:0] VEC_FAST   = 32'h0000_001c;
    localparam logic [31:0] RESET_PC   = 32'h0000_0000;

    // Reset status: supervisor, both interrupts disabled, wide state
    localparam logic [31:0] RESET_STATUS = 32'h0000_00d3;

    // Pipeline fill depth (fetch, decode, execute)
    localparam int unsigned PIPE_STAGES  = 3;

    typedef enum logic [2:0] {
        BMRF_BANK_USER,
        BMRF_BANK_FAST,
        BMRF_BANK_IRQ,
        BMRF_BANK_SUPV,
        BMRF_BANK_ABORT,
        BMRF_BANK_UNDEF
    } bmrf_bank_e;

    typedef struct packed {
        logic       valid;
        logic       is_compact;
        logic [31:0] word;
    } bmrf_insn_s;

    typedef struct packed {
        logic        en;
        logic [3:0]  idx;
        logic [31:0] data;
    } bmrf_wr_s;

    typedef struct packed {
        logic fast;
        logic irq;
        logic abort;
        logic undef;
        logic trap;
    } bmrf_exc_s;

    typedef enum logic [2:0] {
        BMRF_ST_FILL,
        BMRF_ST_RUN,
        BMRF_ST_EXC
    } bmrf_state_e;
endpackage

// File: bmrf_cond_eval.sv
// Condition field evaluator for wide-state instructions
`timescale 1ns/1ns
`default_nettype none
module bmrf_cond_eval (
    input  wire logic [3:0] cond_i,
    input  wire logic       n_i,
    input  wire logic       z_i,
    input  wire logic       c_i,
    input  wire logic       v_i,
    output logic            pass_o
);
    logic pass;
    always_comb begin
        case (cond_i)
            4'h0: pass = z_i;
            4'h1: pass = !z_i;
            4'h2: pass = c_i;
            4'h3: pass = !c_i;
            4'h4: pass = n_i;
            4'h5: pass = !n_i;
            4'h6: pass = v_i;
            4'h7: pass = !v_i;
            4'h8: pass = c_i && !z_i;
            4'h9: pass = !c_i || z_i;
            4'ha: pass = n_i == v_i;
            4'hb: pass = n_i != v_i;
            4'hc: pass = !z_i && (n_i == v_i);
            4'hd: pass = z_i || (n_i != v_i);
            4'he: pass = 1'b1;
            default: pass = 1'b0;
        endcase
    end
    assign pass_o = pass;
endmodule
`default_nettype wire

// File: bmrf_core_state.sv
// Banked register file, status words and exception bookkeeping
//
// Overview of operation
// RULE1: Three stages fetch, decode, execute; execute valid only after pipe fills.
// RULE2: Wide instructions are 32 bits, compact ones 16 bits, by state bit.
// RULE3: Byte, halfword, word data; misaligned word or halfword access is flagged.
// RULE4: Seven modes; changed by software write, interrupt or exception.
// RULE5: Storage is 31 general registers plus 6 status words.
// RULE6: Sixteen registers visible, mapped by current mode.
// RULE7: Index 15 reads the program counter for relative addressing.
// RULE8: Indices 0 to 7 are one shared physical register each.
// RULE9: Indices 8 to 14 select physical copies by mode.
// RULE10: Each exception mode owns private stack and return registers.
// RULE11: Fast interrupt mode owns private copies of indices 8 to 12.
// RULE12: System mode uses the user registers while privileged.
// RULE13: Status word holds negative, zero, carry, overflow flags.
// RULE14: Status word holds two interrupt disables, state bit, five-bit mode.
// RULE15: Each exception mode saves the interrupted status word on entry.
// RULE16: Five exception classes with own modes; simultaneous ones are prioritised.
// RULE17: Entry stores return address and saved status in the entered mode.
// RULE18: Return copies saved status to current and return address to counter.
// RULE19: Wide instructions run only when bits 31 to 28 condition passes.
// RULE20: Reads after a mode change use the new mode's copies.
`timescale 1ns/1ns
`default_nettype none
module bmrf_core_state (
    input  wire logic                  REF_CLK_I,
    input  wire logic                  RESET_I,
    input  wire bmrf_pkg::bmrf_insn_s  INSN_I,
    input  wire logic [3:0]            RD_IDX_A_I,
    input  wire logic [3:0]            RD_IDX_B_I,
    input  wire bmrf_pkg::bmrf_wr_s    WR_I,
    input  wire logic                  PC_ADVANCE_I,
    input  wire logic                  BRANCH_I,
    input  wire logic [31:0]           BRANCH_TARGET_I,
    input  wire logic                  FLAGS_WE_I,
    input  wire logic [3:0]            FLAGS_I,
    input  wire logic                  STATUS_WE_I,
    input  wire logic [31:0]           STATUS_I,
    input  wire logic                  SAVED_WE_I,
    input  wire bmrf_pkg::bmrf_exc_s   EXC_I,
    input  wire logic                  EXC_RETURN_I,
    input  wire logic                  MEM_REQ_I,
    input  wire logic [1:0]            MEM_SIZE_I,
    input  wire logic [31:0]           MEM_ADDR_I,
    output logic [31:0]                RD_DATA_A_O,
    output logic [31:0]                RD_DATA_B_O,
    output logic [31:0]                PC_O,
    output logic [31:0]                STATUS_O,
    output logic [31:0]                SAVED_O,
    output logic                       PRIVILEGED_O,
    output logic                       EXEC_VALID_O,
    output logic                       EXEC_PASS_O,
    output logic [31:0]                EXEC_INSN_O,
    output logic                       MISALIGNED_O,
    output logic                       EXC_TAKEN_O
);
    // Physical general registers: 0-7 shared, 8-12 user, 8-12 fast,
    // 13/14 for user and each of five exception modes, and the counter.
    localparam int unsigned SLOT_U812 = 8;
    localparam int unsigned SLOT_F812 = 13;
    localparam int unsigned SLOT_SPRA = 18;
    localparam int unsigned SLOT_PC   = 30;

    logic [31:0] gpr_q [bmrf_pkg::NUM_GP_PHYS]; // see RULE5
    logic [31:0] status_q;
    logic [31:0] saved_q [bmrf_pkg::NUM_SAVED]; // see RULE15

    logic [31:0] rd_a_q, rd_b_q, saved_rd_q;
    logic [1:0]  fill_q;
    logic [31:0] insn_d1_q, insn_d2_q;
    logic        v_d1_q, v_d2_q;
    logic        exec_valid_q, exec_pass_q, misal_q, exc_taken_q;
    logic [31:0] exec_insn_q;

    wire [4:0] mode = status_q[bmrf_pkg::SW_MODE_HI:bmrf_pkg::SW_MODE_LO]; // see RULE14

    wire flag_n = status_q[bmrf_pkg::SW_NEG_BIT]; // see RULE13
    wire flag_z = status_q[bmrf_pkg::SW_ZERO_BIT];
    wire flag_c = status_q[bmrf_pkg::SW_CARRY_BIT];
    wire flag_v = status_q[bmrf_pkg::SW_OVF_BIT];

    wire compact = status_q[bmrf_pkg::SW_STATE_BIT];

    // Bank from mode; system shares the user bank (see RULE12)
    bmrf_pkg::bmrf_bank_e bank;
    always_comb begin
        case (mode)
            bmrf_pkg::MODE_FAST:  bank = bmrf_pkg::BMRF_BANK_FAST;
            bmrf_pkg::MODE_IRQ:   bank = bmrf_pkg::BMRF_BANK_IRQ;
            bmrf_pkg::MODE_SUPV:  bank = bmrf_pkg::BMRF_BANK_SUPV;
            bmrf_pkg::MODE_ABORT: bank = bmrf_pkg::BMRF_BANK_ABORT;
            bmrf_pkg::MODE_UNDEF: bank = bmrf_pkg::BMRF_BANK_UNDEF;
            default:              bank = bmrf_pkg::BMRF_BANK_USER;
        endcase
    end

    // Logical index to physical slot for a given bank
    function automatic logic [4:0] phys_slot(input logic [3:0] idx, input bmrf_pkg::bmrf_bank_e b);
        logic [4:0] s;
        s = 5'h00;

        if (idx == 4'hf) begin
            s = 5'(SLOT_PC); // see RULE7
        end else if (idx < 4'h8) begin
            s = {1'b0, idx}; // see RULE8
        end else if (idx <= 4'hc) begin
            s = (b == bmrf_pkg::BMRF_BANK_FAST) ? 5'(SLOT_F812) + 5'(idx - 4'h8)
                                                : 5'(SLOT_U812) + 5'(idx - 4'h8); // see RULE9, RULE11
        end else begin
            s = 5'(SLOT_SPRA) + {1'b0, 3'(b), 1'b0} + 5'(idx - 4'hd); // see RULE10
        end
        return s;
    endfunction

    // Exception priority and target
    logic        exc_any;
    logic [4:0]  exc_mode;
    logic [31:0] exc_vec;
    logic        fast_ok, irq_ok;

    assign fast_ok = EXC_I.fast && !status_q[bmrf_pkg::SW_FIQD_BIT];
    assign irq_ok  = EXC_I.irq && !status_q[bmrf_pkg::SW_IRQD_BIT];
    assign exc_any = EXC_I.abort || fast_ok || irq_ok || EXC_I.undef || EXC_I.trap;

    always_comb begin
        // Abort outranks interrupts so a faulting access is never replayed blind
        if (EXC_I.abort) begin // see RULE16
            exc_mode = bmrf_pkg::MODE_ABORT;
            exc_vec  = bmrf_pkg::VEC_ABORT;
        end else if (fast_ok) begin
            exc_mode = bmrf_pkg::MODE_FAST;
            exc_vec  = bmrf_pkg::VEC_FAST;
        end else if (irq_ok) begin
            exc_mode = bmrf_pkg::MODE_IRQ;
            exc_vec  = bmrf_pkg::VEC_IRQ;
        end else if (EXC_I.undef) begin
            exc_mode = bmrf_pkg::MODE_UNDEF;
            exc_vec  = bmrf_pkg::VEC_UNDEF;
        end else begin
            exc_mode = bmrf_pkg::MODE_SUPV;
            exc_vec  = bmrf_pkg::VEC_TRAP;
        end
    end

    bmrf_pkg::bmrf_bank_e exc_bank;
    always_comb begin
        case (exc_mode)
            bmrf_pkg::MODE_FAST:  exc_bank = bmrf_pkg::BMRF_BANK_FAST;
            bmrf_pkg::MODE_IRQ:   exc_bank = bmrf_pkg::BMRF_BANK_IRQ;
            bmrf_pkg::MODE_ABORT: exc_bank = bmrf_pkg::BMRF_BANK_ABORT;
            bmrf_pkg::MODE_UNDEF: exc_bank = bmrf_pkg::BMRF_BANK_UNDEF;
            default:              exc_bank = bmrf_pkg::BMRF_BANK_SUPV;
        endcase
    end

    wire [2:0]  saved_sel = 3'(bank) - 3'h1;
    wire [2:0]  exc_sel   = 3'(exc_bank) - 3'h1;
    wire        has_saved = bank != bmrf_pkg::BMRF_BANK_USER;

    wire [4:0]  ra_slot   = phys_slot(4'(bmrf_pkg::RA_INDEX), bank);
    wire [4:0]  exc_ra    = phys_slot(4'(bmrf_pkg::RA_INDEX), exc_bank);
    wire [4:0]  wr_slot   = phys_slot(WR_I.idx, bank);
    wire [4:0]  slot_a    = phys_slot(RD_IDX_A_I, bank);
    wire [4:0]  slot_b    = phys_slot(RD_IDX_B_I, bank);

    wire [31:0] pc_step   = compact ? 32'h0000_0002 : 32'h0000_0004; // see RULE2
    wire        do_return = EXC_RETURN_I && has_saved && !exc_any;

    // Register update: exception entry outranks return, branch and writes
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            for (int i = 0; i < int'(bmrf_pkg::NUM_GP_PHYS); i++) begin
                gpr_q[i] <= 32'h0000_0000;
            end
            gpr_q[SLOT_PC] <= bmrf_pkg::RESET_PC;
        end else if (exc_any) begin
            gpr_q[exc_ra]  <= gpr_q[SLOT_PC]; // see RULE17
            gpr_q[SLOT_PC] <= exc_vec;
        end else if (do_return) begin
            gpr_q[SLOT_PC] <= gpr_q[ra_slot]; // see RULE18
        end else begin
            if (WR_I.en) begin
                gpr_q[wr_slot] <= WR_I.data;
            end
            if (BRANCH_I) begin
                gpr_q[SLOT_PC] <= BRANCH_TARGET_I;
            end else if (PC_ADVANCE_I && !(WR_I.en && WR_I.idx == 4'hf)) begin
                gpr_q[SLOT_PC] <= gpr_q[SLOT_PC] + pc_step;
            end
        end
    end

    // Status words; mode may change by software, interrupt or exception
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            status_q <= bmrf_pkg::RESET_STATUS;
            for (int i = 0; i < int'(bmrf_pkg::NUM_SAVED); i++) begin
                saved_q[i] <= 32'h0000_0000;
            end
        end else if (exc_any) begin
            saved_q[exc_sel] <= status_q; // see RULE15, RULE17
            status_q[bmrf_pkg::SW_MODE_HI:bmrf_pkg::SW_MODE_LO] <= exc_mode; // see RULE4
            status_q[bmrf_pkg::SW_IRQD_BIT]  <= 1'b1;
            status_q[bmrf_pkg::SW_STATE_BIT] <= 1'b0;
            if (exc_mode == bmrf_pkg::MODE_FAST) begin
                status_q[bmrf_pkg::SW_FIQD_BIT] <= 1'b1;
            end
        end else if (do_return) begin
            status_q <= saved_q[saved_sel]; // see RULE18
        end else begin
            if (STATUS_WE_I && mode != bmrf_pkg::MODE_USER) begin
                status_q <= STATUS_I; // see RULE4
            end else if (FLAGS_WE_I) begin
                status_q[bmrf_pkg::SW_NEG_BIT:bmrf_pkg::SW_OVF_BIT] <= FLAGS_I;
            end
            if (SAVED_WE_I && has_saved) begin
                saved_q[saved_sel] <= STATUS_I;
            end
        end
    end

    // Read ports use the bank decoded from the registered mode, so a
    // mode change is seen by the very next read (see RULE6, RULE20)
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            rd_a_q     <= 32'h0000_0000;
            rd_b_q     <= 32'h0000_0000;
            saved_rd_q <= 32'h0000_0000;
        end else begin
            rd_a_q     <= gpr_q[slot_a];
            rd_b_q     <= gpr_q[slot_b];
            saved_rd_q <= has_saved ? saved_q[saved_sel] : status_q;
        end
    end

    // Fetch, decode, execute pipe; flushed on exception entry, return or branch, not on a write to index 15 (see RULE1)
    logic cond_pass;
    bmrf_cond_eval u_cond (
        .cond_i (insn_d2_q[bmrf_pkg::COND_HI:bmrf_pkg::COND_LO]),
        .n_i    (flag_n),
        .z_i    (flag_z),
        .c_i    (flag_c),
        .v_i    (flag_v),
        .pass_o (cond_pass)
    );

    wire flush = exc_any || do_return || BRANCH_I;

    wire [31:0] fetched = compact ? {16'h0000, INSN_I.word[bmrf_pkg::COMPACT_W-1:0]} : INSN_I.word; // see RULE2

    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I || flush) begin
            fill_q    <= 2'h0;
            v_d1_q    <= 1'b0;
            v_d2_q    <= 1'b0;
            insn_d1_q <= 32'h0000_0000;
            insn_d2_q <= 32'h0000_0000;
        end else begin
            v_d1_q    <= INSN_I.valid;
            insn_d1_q <= fetched;
            v_d2_q    <= v_d1_q;
            insn_d2_q <= insn_d1_q;
            if (INSN_I.valid && fill_q != 2'(bmrf_pkg::PIPE_STAGES - 1)) begin
                fill_q <= fill_q + 2'h1;
            end
        end
    end

    // Misaligned check: size 1 halfword, 2 word (see RULE3)
    wire misal = MEM_REQ_I && ((MEM_SIZE_I == 2'h1 && MEM_ADDR_I[0])
                 || (MEM_SIZE_I == 2'h2 && MEM_ADDR_I[1:0] != 2'h0));

    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            exec_valid_q <= 1'b0;
            exec_pass_q  <= 1'b0;
            exec_insn_q  <= 32'h0000_0000;
            misal_q      <= 1'b0;
            exc_taken_q  <= 1'b0;
        end else begin
            exec_valid_q <= v_d2_q && !flush; // see RULE1
            exec_pass_q  <= v_d2_q && !flush && (compact || cond_pass); // see RULE19
            exec_insn_q  <= insn_d2_q;
            misal_q      <= misal;
            exc_taken_q  <= exc_any;
        end
    end

    assign RD_DATA_A_O  = rd_a_q;
    assign RD_DATA_B_O  = rd_b_q;
    assign PC_O         = gpr_q[SLOT_PC];
    assign STATUS_O     = status_q;
    assign SAVED_O      = saved_rd_q;
    assign PRIVILEGED_O = status_q[bmrf_pkg::SW_MODE_HI:bmrf_pkg::SW_MODE_LO] != bmrf_pkg::MODE_USER; // see RULE12
    assign EXEC_VALID_O = exec_valid_q;
    assign EXEC_PASS_O  = exec_pass_q;
    assign EXEC_INSN_O  = exec_insn_q;
    assign MISALIGNED_O = misal_q;
    assign EXC_TAKEN_O  = exc_taken_q;
endmodule
`default_nettype wire

// File: bmrf_exec_model.sv
// Instruction source feeding the banked register file
`timescale 1ns/1ns
`default_nettype none
module bmrf_exec_model (
    input  wire logic           clk_i,
    input  wire logic           run_i,
    output bmrf_pkg::bmrf_insn_s insn_o = '0,
    output logic                adv_o = 1'b0
);
    logic [3:0]  cnt_q = 4'h0;
    logic [31:0] w;
    logic [31:0] sent[$];

    // Condition field walks all sixteen codes
    always @(posedge clk_i) begin
        if (run_i) begin
            w = {cnt_q, 28'($urandom)};
            sent.push_back(w);
            cnt_q <= cnt_q + 4'h1;
            insn_o <= '{1'b1, 1'b0, w};
        end else begin
            // Idle word toggles so stale data stands out
            insn_o <= '{1'b0, 1'b0, ~insn_o.word};
        end
        adv_o <= run_i;
    end
endmodule
`default_nettype wire

// File: bmrf_core_state_asserts.sv
// Port checks for the banked register file
`timescale 1ns/1ns
`default_nettype none
module bmrf_core_state_chk (
    input wire logic                REF_CLK_I,
    input wire logic                RESET_I,
    input wire bmrf_pkg::bmrf_wr_s  WR_I,
    input wire logic                BRANCH_I,
    input wire logic                FLAGS_WE_I,
    input wire logic [3:0]          FLAGS_I,
    input wire logic                STATUS_WE_I,
    input wire bmrf_pkg::bmrf_exc_s EXC_I,
    input wire logic                EXC_RETURN_I,
    input wire logic                MEM_REQ_I,
    input wire logic [1:0]          MEM_SIZE_I,
    input wire logic [31:0]         MEM_ADDR_I,
    input wire logic [31:0]         PC_O,
    input wire logic [31:0]         STATUS_O,
    input wire logic                PRIVILEGED_O,
    input wire logic                MISALIGNED_O,
    input wire logic                EXC_TAKEN_O
);
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (RESET_I);

    wire [4:0] md = STATUS_O[4:0];
    wire fiq_on = EXC_I.fast & ~STATUS_O[6];
    wire irq_on = EXC_I.irq & ~STATUS_O[7];
    wire any_on = EXC_I.abort | fiq_on | irq_on | EXC_I.undef | EXC_I.trap;
    wire calm = ~any_on & ~EXC_RETURN_I;
    wire mis = MEM_SIZE_I == 2'h2 ? |MEM_ADDR_I[1:0] : (MEM_SIZE_I == 2'h1) & MEM_ADDR_I[0];

    a_abort_first: assert property (EXC_I.abort |=> PC_O == bmrf_pkg::VEC_ABORT && md == bmrf_pkg::MODE_ABORT)
        else $error("abort entry wrong");
    a_fast_entry: assert property (fiq_on && !EXC_I.abort |=> PC_O == bmrf_pkg::VEC_FAST && STATUS_O[7:6] == 2'h3)
        else $error("fast entry wrong");
    a_irq_entry: assert property (irq_on && !EXC_I.abort && !fiq_on |=> md == bmrf_pkg::MODE_IRQ && STATUS_O[7])
        else $error("irq entry wrong");
    a_taken_flag: assert property (any_on |=> EXC_TAKEN_O)
        else $error("taken flag missing");
    a_no_spurious: assert property (!any_on |=> !EXC_TAKEN_O)
        else $error("taken flag without cause");
    a_user_locked: assert property (md == bmrf_pkg::MODE_USER && STATUS_WE_I && !FLAGS_WE_I && calm |=> $stable(STATUS_O))
        else $error("user status changed");
    a_flag_write: assert property (FLAGS_WE_I && !STATUS_WE_I && calm |=> STATUS_O[31:28] == $past(FLAGS_I))
        else $error("flags not written");
    a_pc_write: assert property (WR_I.en && WR_I.idx == 4'hf && !BRANCH_I && calm |=> PC_O == $past(WR_I.data))
        else $error("pc write lost");
    a_priv_mode: assert property (PRIVILEGED_O == (md != bmrf_pkg::MODE_USER))
        else $error("privilege flag wrong");
    a_misalign_flag: assert property (MEM_REQ_I && MEM_SIZE_I != 2'h3 |=> MISALIGNED_O == $past(mis))
        else $error("misalign flag wrong");

    c_irq: cover property (irq_on ##1 EXC_TAKEN_O);
    c_ret: cover property (EXC_RETURN_I && md == bmrf_pkg::MODE_IRQ);
    c_mis: cover property (MEM_REQ_I ##1 MISALIGNED_O);
endmodule
bind bmrf_core_state bmrf_core_state_chk bmrf_core_state_chk_i (
    .REF_CLK_I(REF_CLK_I), .RESET_I(RESET_I), .WR_I(WR_I), .BRANCH_I(BRANCH_I), .FLAGS_WE_I(FLAGS_WE_I),
    .FLAGS_I(FLAGS_I), .STATUS_WE_I(STATUS_WE_I), .EXC_I(EXC_I), .EXC_RETURN_I(EXC_RETURN_I),
    .MEM_REQ_I(MEM_REQ_I), .MEM_SIZE_I(MEM_SIZE_I), .MEM_ADDR_I(MEM_ADDR_I), .PC_O(PC_O),
    .STATUS_O(STATUS_O), .PRIVILEGED_O(PRIVILEGED_O), .MISALIGNED_O(MISALIGNED_O), .EXC_TAKEN_O(EXC_TAKEN_O));
`default_nettype wire

// File: banked_mode_register_file_test.sv
// Self-checking bench for the banked register file
`timescale 1ns/1ns
`default_nettype none
module banked_mode_register_file_test;
    logic                 clk = 1'b0;
    logic                 rst = 1'b1;
    bmrf_pkg::bmrf_insn_s insn;
    bmrf_pkg::bmrf_wr_s   wr = '0;
    bmrf_pkg::bmrf_exc_s  exc = '0;
    logic [3:0]  rd_a = '0, rd_b = '0, fl = '0, fv = '0;
    logic        adv, run = '0, br = '0, fwe = '0, swe = '0, svwe = '0, ret = '0, mreq = '0;
    logic [1:0]  msz = '0, sz;
    logic [31:0] bt = '0, st = '0, maddr = '0, rda, rdb, pc, stat, saved, ei, w, d, pcm;
    logic        priv, ev, ep, mis, et;
    logic [31:0] mem[40];
    int          failures = 0, checked = 0, nexec = 0;
    logic [4:0]  mds[6] = '{bmrf_pkg::MODE_SUPV, bmrf_pkg::MODE_FAST, bmrf_pkg::MODE_IRQ,
                            bmrf_pkg::MODE_ABORT, bmrf_pkg::MODE_UNDEF, bmrf_pkg::MODE_SYSTEM};
    logic [4:0]  emds[5] = '{bmrf_pkg::MODE_FAST, bmrf_pkg::MODE_IRQ, bmrf_pkg::MODE_ABORT,
                             bmrf_pkg::MODE_UNDEF, bmrf_pkg::MODE_SUPV};
    logic [31:0] vecs[5] = '{bmrf_pkg::VEC_FAST, bmrf_pkg::VEC_IRQ, bmrf_pkg::VEC_ABORT,
                             bmrf_pkg::VEC_UNDEF, bmrf_pkg::VEC_TRAP};

    initial forever #2 clk = ~clk;

    bmrf_exec_model bmrf_exec_model_i (.clk_i(clk), .run_i(run), .insn_o(insn), .adv_o(adv));
    bmrf_core_state bmrf_core_state_i (
        .REF_CLK_I(clk), .RESET_I(rst), .INSN_I(insn), .RD_IDX_A_I(rd_a), .RD_IDX_B_I(rd_b),
        .WR_I(wr), .PC_ADVANCE_I(adv), .BRANCH_I(br), .BRANCH_TARGET_I(bt), .FLAGS_WE_I(fwe),
        .FLAGS_I(fl), .STATUS_WE_I(swe), .STATUS_I(st), .SAVED_WE_I(svwe), .EXC_I(exc),
        .EXC_RETURN_I(ret), .MEM_REQ_I(mreq), .MEM_SIZE_I(msz), .MEM_ADDR_I(maddr),
        .RD_DATA_A_O(rda), .RD_DATA_B_O(rdb), .PC_O(pc), .STATUS_O(stat), .SAVED_O(saved),
        .PRIVILEGED_O(priv), .EXEC_VALID_O(ev), .EXEC_PASS_O(ep), .EXEC_INSN_O(ei),
        .MISALIGNED_O(mis), .EXC_TAKEN_O(et));

    // Model slots: 0-7 shared, 16-20 fast 8-12, 21 up stack/return pairs
    function automatic int phys(input logic [4:0] m, input int i);
        int b;
        b = 0;
        foreach (emds[k]) if (m == emds[k] && k < 4) b = k + 1;
        if (m == bmrf_pkg::MODE_SUPV) b = 5;
        if (i < 8 || (i < 13 && b != 1)) return i;
        if (i < 13) return i + 8;
        return 21 + 2 * b + i - 13;
    endfunction

    function automatic logic cpass(input logic [3:0] c, f);
        logic r;
        case (c[3:1])
            3'h0: r = f[2];
            3'h1: r = f[1];
            3'h2: r = f[3];
            3'h3: r = f[0];
            3'h4: r = f[1] & ~f[2];
            3'h5: r = f[3] == f[0];
            3'h6: r = ~f[2] & (f[3] == f[0]);
            default: r = 1'b1;
        endcase
        return (c == 4'hf) ? 1'b0 : r ^ c[0];
    endfunction

    task automatic chk(input string n, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic set_st(input logic [31:0] v);
        @(posedge clk) begin swe <= 1'b1; st <= v; end
        @(posedge clk) swe <= 1'b0;
    endtask

    task automatic wreg(input logic [4:0] m, input int i, input logic [31:0] v);
        @(posedge clk) wr <= '{1'b1, 4'(i), v};
        @(posedge clk) wr.en <= 1'b0;
        mem[phys(m, i)] = v;
    endtask

    task automatic rreg(input logic [4:0] m, input int i);
        @(posedge clk) begin rd_a <= 4'(i); rd_b <= 4'(14 - i); end
        @(posedge clk) #1;
        chk("read a", mem[phys(m, i)], rda);
        chk("read b", mem[phys(m, 14 - i)], rdb);
    endtask

    task automatic exc_case(input logic [4:0] e, input logic [31:0] v, input logic [4:0] m, input logic [31:0] s0);
        logic [31:0] pcv;
        pcv = $urandom & 32'hffff_fffc;
        set_st(s0);
        @(posedge clk) begin br <= 1'b1; bt <= pcv; end
        @(posedge clk) begin br <= 1'b0; exc <= bmrf_pkg::bmrf_exc_s'(e); end
        @(posedge clk) exc <= '0;
        #1 chk("vector", v, pc);
        chk("mode", 32'(m), 32'(stat[4:0]));
        chk("taken", 1, 32'(et));
        @(posedge clk) rd_a <= 4'he;
        @(posedge clk) #1 chk("return address", pcv, rda);
        chk("saved", s0, saved);
        @(posedge clk) ret <= 1'b1;
        @(posedge clk) ret <= 1'b0;
        #1 chk("restored status", s0, stat);
        chk("restored pc", pcv, pc);
    endtask

    always @(negedge clk) begin
        if (ev === 1'b1) begin
            w = bmrf_exec_model_i.sent.size() ? bmrf_exec_model_i.sent.pop_front() : ~ei;
            nexec++;
            chk("executed word", w, ei);
            chk("condition", 32'(cpass(w[31:28], fv)), 32'(ep));
        end
    end

    initial begin
        void'($urandom(32'hff88a7ba));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        #1 chk("reset status", bmrf_pkg::RESET_STATUS, stat);
        chk("reset pc", bmrf_pkg::RESET_PC, pc);
        for (int p = 0; p < 2; p++) begin
            foreach (mds[j]) begin
                set_st({24'h0, 3'b110, mds[j]});
                #1 chk("privileged", 1, 32'(priv));
                for (int i = 0; i < 15; i++) begin
                    if (p == 0) wreg(mds[j], i, $urandom);
                    else rreg(mds[j], i);
                end
            end
        end
        d = $urandom & 32'hffff_fffc;
        wreg(mds[5], 15, d);
        #1 chk("pc write", d, pc);
        @(posedge clk) rd_a <= 4'hf;
        @(posedge clk) #1 chk("pc read", d, rda);
        set_st(32'h13);
        d = $urandom;
        @(posedge clk) begin svwe <= 1'b1; st <= d; end
        @(posedge clk) svwe <= 1'b0;
        @(posedge clk) #1 chk("saved write", d, saved);
        set_st(32'hd3);
        @(posedge clk) exc <= bmrf_pkg::bmrf_exc_s'(5'h18);
        @(posedge clk) exc <= '0;
        #1 chk("masked", 32'h0, 32'(et));
        for (int k = 0; k < 5; k++) exc_case(5'h10 >> k, vecs[k], emds[k], 32'h13);
        exc_case(5'h1f, vecs[2], emds[2], 32'h13);
        exc_case(5'h08, vecs[1], emds[1], 32'h10);
        set_st(32'h13);
        #1 chk("user locked", 32'h10, stat);
        chk("user unprivileged", 0, 32'(priv));
        @(posedge clk) exc <= bmrf_pkg::bmrf_exc_s'(5'h01);
        @(posedge clk) exc <= '0;
        #1 chk("trap mode", 32'(emds[4]), 32'(stat[4:0]));
        pcm = vecs[4];
        for (int f = 0; f < 4; f++) begin
            @(posedge clk) begin fwe <= 1'b1; fl <= 4'($urandom); end
            @(posedge clk) fwe <= 1'b0;
            fv = fl;
            #1 chk("flags", 32'(fv), 32'(stat[31:28]));
            @(posedge clk) run <= 1'b1;
            repeat (16) @(posedge clk);
            run <= 1'b0;
            repeat (6) @(posedge clk);
            pcm += 64;
            #1 chk("pc advance", pcm, pc);
        end
        chk("executed count", 64, nexec);
        repeat (24) begin
            sz = 2'($urandom % 3);
            d = $urandom;
            @(posedge clk) begin mreq <= 1'b1; msz <= sz; maddr <= d; end
            @(posedge clk) mreq <= 1'b0;
            #1 chk("misaligned", 32'((sz == 2'h2 && d[1:0] != 2'h0) || (sz == 2'h1 && d[0])), 32'(mis));
        end
        final_report();
    end

    initial begin
        #40000;
        failures++;
        final_report();
    end
endmodule
`default_nettype wire
